// ---- design/evcr_config_reg.sv ----
// Enhanced volatile configuration register with its serial front end.
// Assumes the serial clock, select, data line 0 and the voltage detector
// come from outside the clk domain; they are synchronised here.

`timescale 1ns/1ps
`default_nettype none

module evcr_config_reg
    import evcr_pkg::*;
#(
    parameter int         VPP_TIMEOUT_CYC = int'(EVCR_VPP_TIMEOUT_CYC),
    parameter logic [7:0] OP_WRITE_CFG    = 8'h61,
    parameter logic [7:0] OP_READ_CFG     = 8'h65,
    parameter logic [7:0] OP_CLEAR_FLAGS  = 8'h50,
    parameter logic [7:0] OP_QUAD_PROG    = 8'h32,
    parameter logic [7:0] OP_QUAD_EXTPROG = 8'h12,
    parameter logic [7:0] OP_PAGE_PROG    = 8'h02,
    parameter logic [7:0] OP_SECT_ERASE   = 8'hd8,
    parameter logic [7:0] OP_SUB_ERASE    = 8'h20
)
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        serialClk,
    input  wire logic        chipSelN,
    input  wire logic        dataIn,
    input  wire logic        vppHigh,
    input  wire logic        nvQuadN,
    input  wire logic        nvDualN,
    input  wire logic        nvHoldEn,
    input  wire logic [2:0]  nvDrive,
    output logic             dataOut,
    output logic             dataOutEn,
    output logic [7:0]       enhancedConfig,
    output evcr_proto_t      protocol,
    output logic             tempExtended,
    output logic             holdResetEnable,
    output logic             accelEnable,
    output logic [2:0]       driveStrength,
    output logic             vppErrorFlag,
    output logic             modifyStart,
    output logic             modifyAccel
);

    localparam int TW = $clog2(VPP_TIMEOUT_CYC + 1);
    localparam logic [TW-1:0] TIMER_LAST = TW'(VPP_TIMEOUT_CYC - 1);

    typedef struct packed {
        logic [2:0]  sclkSync;
        logic [2:0]  csnSync;
        logic [2:0]  dinSync;
        logic [2:0]  vppSync;
        logic        sclkF;
        logic        csnF;
        logic        dinF;
        logic        vppF;
        logic        loadPending;
        logic [7:0]  cfg;
        logic [7:0]  shiftIn;
        logic [4:0]  bitCnt;
        logic [7:0]  opcode;
        logic [7:0]  shiftOut;
        logic        readPhase;
        evcr_wait_t  waitSt;
        logic [TW-1:0] timer;
        logic        tempExt;
        logic        err;
        evcr_proto_t proto;
        logic        holdEn;
        logic        accelEn;
        logic [2:0]  drive;
        logic        dOut;
        logic        dOutEn;
        logic        modGo;
        logic        modAccel;
    } evcr_state_t;

    evcr_state_t q;
    evcr_state_t n;

    logic       sclkRise, sclkFall, selStart, deselect, vppFall;
    logic       frameOk, wrCommit, clrEvt, quadMod, plainMod;
    logic [7:0] wrExpect;

    // Next state of the whole block
    always_comb
    begin
        n = q;
        n.modGo = 1'b0;

        // Three-stage sampling; a level counts once stages two and three agree
        n.sclkSync = {q.sclkSync[1:0], serialClk};
        n.csnSync  = {q.csnSync[1:0], chipSelN};
        n.dinSync  = {q.dinSync[1:0], dataIn};
        n.vppSync  = {q.vppSync[1:0], vppHigh};
        n.sclkF = (q.sclkSync[1] == q.sclkSync[2]) ? q.sclkSync[2] : q.sclkF;
        n.csnF  = (q.csnSync[1] == q.csnSync[2]) ? q.csnSync[2] : q.csnF;
        n.dinF  = (q.dinSync[1] == q.dinSync[2]) ? q.dinSync[2] : q.dinF;
        n.vppF  = (q.vppSync[1] == q.vppSync[2]) ? q.vppSync[2] : q.vppF;

        sclkRise = n.sclkF & ~q.sclkF;
        sclkFall = ~n.sclkF & q.sclkF;
        selStart = ~n.csnF & q.csnF;
        deselect = n.csnF & ~q.csnF;
        vppFall  = q.vppF & ~n.vppF;

        // Opcode is only trusted once a full byte arrived in this frame
        frameOk  = deselect && (q.bitCnt >= EVCR_OP_BITS);
        wrCommit = deselect && (q.opcode == OP_WRITE_CFG)
                   && (q.bitCnt == EVCR_WRITE_BITS);
        clrEvt   = frameOk && (q.opcode == OP_CLEAR_FLAGS)
                   && (q.bitCnt == EVCR_OP_BITS);
        quadMod  = frameOk && ((q.opcode == OP_QUAD_PROG)
                   || (q.opcode == OP_QUAD_EXTPROG)
                   || ((q.proto == EVCR_PROTO_QUAD)
                       && ((q.opcode == OP_PAGE_PROG)
                           || (q.opcode == OP_SECT_ERASE)
                           || (q.opcode == OP_SUB_ERASE))));
        plainMod = frameOk && !quadMod && ((q.opcode == OP_PAGE_PROG)
                   || (q.opcode == OP_SECT_ERASE)
                   || (q.opcode == OP_SUB_ERASE));

        // written value, reserved drive codes keep old strength
        wrExpect = q.shiftIn;
        wrExpect[EVCR_RSVD_BIT] = 1'b0;
        if ((q.shiftIn[2:0] == EVCR_DRIVE_RSV0)
            || (q.shiftIn[2:0] == EVCR_DRIVE_RSV1))
            wrExpect[2:0] = q.cfg[2:0];

        // Serial frame handling
        if (selStart)
        begin
            n.bitCnt    = 5'h00;
            n.readPhase = 1'b0;
        end
        if (!n.csnF && sclkRise)
        begin
            n.shiftIn = {q.shiftIn[6:0], n.dinF};
            if (q.bitCnt != 5'h1f)
                n.bitCnt = q.bitCnt + 5'h01;
            if (q.bitCnt == EVCR_OP_BITS - 5'h01)
            begin
                n.opcode = {q.shiftIn[6:0], n.dinF};
                if (n.opcode == OP_READ_CFG)
                begin
                    n.readPhase = 1'b1;
                    n.shiftOut  = q.cfg;
                end
            end
        end
        // Readback repeats the byte for as long as the host clocks
        if (!n.csnF && sclkFall && q.readPhase)
        begin
            n.dOut     = q.shiftOut[7];
            n.shiftOut = {q.shiftOut[6:0], q.shiftOut[7]};
            n.dOutEn   = 1'b1;
        end
        if (deselect)
        begin
            n.dOutEn    = 1'b0;
            n.readPhase = 1'b0;
        end

        if (q.loadPending)
        begin
            n.loadPending = 1'b0;
            n.cfg = {nvQuadN, nvDualN, 1'b0, nvHoldEn, 1'b1, nvDrive};
        end
        // write applies at end of instruction
        else if (wrCommit)
            n.cfg = wrExpect;

        // leave temporary extended on voltage falling edge
        if (vppFall)
            n.tempExt = 1'b0;

        // clear first so a same-cycle error still sets
        if (clrEvt)
            n.err = 1'b0;

        // accelerated modify waits for the voltage
        case (q.waitSt)
            EVCR_W_IDLE:
            begin
                if (quadMod && !q.cfg[EVCR_ACCEL_BIT])
                begin
                    n.waitSt = EVCR_W_VPP;
                    n.timer  = '0;
                    // quad protocol falls back to extended
                    if (q.proto == EVCR_PROTO_QUAD)
                        n.tempExt = 1'b1;
                end
                else if (quadMod || plainMod)
                begin
                    n.modGo    = 1'b1;
                    n.modAccel = 1'b0;
                end
            end
            EVCR_W_VPP:
            begin
                n.timer = q.timer + {{(TW-1){1'b0}}, 1'b1};
                if (n.vppF)
                begin
                    n.modGo    = 1'b1;
                    n.modAccel = 1'b1;
                    n.waitSt   = EVCR_W_IDLE;
                end
                else if (q.timer == TIMER_LAST)
                begin
                    n.modGo    = 1'b1;
                    n.modAccel = 1'b0;
                    n.err      = 1'b1;
                    n.waitSt   = EVCR_W_IDLE;
                end
            end
            default: n.waitSt = EVCR_W_IDLE;
        endcase

        if (n.tempExt)
            n.proto = EVCR_PROTO_EXT;
        else if (!n.cfg[EVCR_QUAD_BIT])
            n.proto = EVCR_PROTO_QUAD;
        else if (!n.cfg[EVCR_DUAL_BIT])
            n.proto = EVCR_PROTO_DUAL;
        else
            n.proto = EVCR_PROTO_EXT;

        n.holdEn  = n.cfg[EVCR_HOLD_BIT];
        n.accelEn = ~n.cfg[EVCR_ACCEL_BIT];
        n.drive   = n.cfg[EVCR_DRIVE_MSB:0];
    end

    // State register; reset keeps constants only, image loads one cycle later
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            q             <= '0;
            q.csnSync     <= 3'h7;
            q.csnF        <= 1'b1;
            q.loadPending <= 1'b1;
            q.cfg         <= EVCR_CFG_RESET;
            q.waitSt      <= EVCR_W_IDLE;
            q.proto       <= EVCR_PROTO_EXT;
            q.holdEn      <= 1'b1;
            q.drive       <= EVCR_DRIVE_30;
        end
        else
            q <= n;
    end

    assign dataOut         = q.dOut;
    assign dataOutEn       = q.dOutEn;
    assign enhancedConfig  = q.cfg;
    assign protocol        = q.proto;
    assign tempExtended    = q.tempExt;
    assign holdResetEnable = q.holdEn;
    assign accelEnable     = q.accelEn;
    assign driveStrength   = q.drive;
    assign vppErrorFlag    = q.err;
    assign modifyStart     = q.modGo;
    assign modifyAccel     = q.modAccel;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_quad_wins;
        !q.cfg[EVCR_QUAD_BIT] && !q.tempExt |-> protocol == EVCR_PROTO_QUAD;
    endproperty
    a_quad_wins: assert property (p_quad_wins)
        else $error("quad bit low but protocol not quad");

    property p_dual_sel;
        q.cfg[7:6] == 2'b10 && !q.tempExt |-> protocol == EVCR_PROTO_DUAL;
    endproperty
    a_dual_sel: assert property (p_dual_sel)
        else $error("dual selection not honoured");

    property p_ext_sel;
        q.cfg[7:6] == 2'b11 |-> protocol == EVCR_PROTO_EXT;
    endproperty
    a_ext_sel: assert property (p_ext_sel)
        else $error("extended protocol not restored");

    property p_rsvd_zero;
        ##1 enhancedConfig[EVCR_RSVD_BIT] == 1'b0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved bit not zero");

    property p_write_applies;
        wrCommit && !q.loadPending |=> enhancedConfig == $past(wrExpect);
    endproperty
    a_write_applies: assert property (p_write_applies)
        else $error("write not applied after instruction end");

    property p_err_sticky;
        vppErrorFlag && !clrEvt |=> vppErrorFlag;
    endproperty
    a_err_sticky: assert property (p_err_sticky)
        else $error("voltage error flag dropped without clear");

    property p_temp_ext_hold;
        tempExtended && !vppFall |=> tempExtended
            && protocol == EVCR_PROTO_EXT;
    endproperty
    a_temp_ext_hold: assert property (p_temp_ext_hold)
        else $error("left temporary extended without voltage fall");

    property p_timeout;
        q.waitSt == EVCR_W_VPP && q.timer == TIMER_LAST && !n.vppF
            |=> modifyStart && !modifyAccel && vppErrorFlag;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("missed deadline not flagged");

    property p_hold_follow;
        ##1 holdResetEnable == enhancedConfig[EVCR_HOLD_BIT];
    endproperty
    a_hold_follow: assert property (p_hold_follow)
        else $error("hold enable differs from bit 4");

    property p_power_load;
        q.loadPending |=> enhancedConfig[EVCR_HOLD_BIT] == $past(nvHoldEn)
            && driveStrength == $past(nvDrive);
    endproperty
    a_power_load: assert property (p_power_load)
        else $error("power-on image not loaded");

endmodule

`default_nettype wire

// ---- design/evcr_pkg.sv ----
// Constants, types and layout of the enhanced volatile configuration block.
// Assumes a 10 MHz system clock; every other clock is sampled as data.
//
// Behaviour
// - Quad bit (bit 7) at 0 selects quad I/O protocol; 1 leaves the choice to the dual bit.
// - Dual bit (bit 6) at 0 with quad bit 1 selects dual protocol.
// - Both protocol bits at 0: quad protocol wins, dual ignored.
// - Bits back to 1 return to extended; quad 1 with dual 0 is dual.
// - Protocol change applies right when the write instruction completes.
// - Bit 4 at 0 disables the hold/reset pin function; 1 restores it.
// - After power-up hold/reset returns unless non-volatile bit 4 is 0.
// - Bit 3 at 0 permits accelerating voltage; 1 disables it.
// - Accelerator bit only matters for quad modify operations.
// - Accelerated quad modify in quad protocol: extended until voltage falls.
// - Status polling and suspend stay accepted while temporarily extended.
// - Voltage late beyond 200 ms: modify at normal speed, error flag set.
// - Bits 2..0 encode driver impedance; codes 000 and 100 reserved.
// - Power-up driver strength comes from non-volatile bits, 30 ohm default.
// - Power-on loads non-volatile settings; later writes override them.
// - Voltage error flag stays set until clear-flag-status instruction.

package evcr_pkg;

    // Field positions of enhanced_volatile_config
    localparam int EVCR_QUAD_BIT   = 7;
    localparam int EVCR_DUAL_BIT   = 6;
    localparam int EVCR_RSVD_BIT   = 5;
    localparam int EVCR_HOLD_BIT   = 4;
    localparam int EVCR_ACCEL_BIT  = 3;
    localparam int EVCR_DRIVE_MSB  = 2;

    // Reset value: extended protocol, hold on, accelerator off, 30 ohm
    localparam logic [7:0] EVCR_CFG_RESET = 8'hdf;
    localparam logic [2:0] EVCR_DRIVE_30  = 3'h7;
    localparam logic [2:0] EVCR_DRIVE_RSV0 = 3'h0;
    localparam logic [2:0] EVCR_DRIVE_RSV1 = 3'h4;

    // Frame lengths in serial bits
    localparam logic [4:0] EVCR_OP_BITS    = 5'h08;
    localparam logic [4:0] EVCR_WRITE_BITS = 5'h10;

    // Accelerating voltage deadline, longest time rounds down
    localparam longint EVCR_CLK_HZ        = 10_000_000;
    localparam longint EVCR_VPP_TIMEOUT_MS = 200;
    localparam longint EVCR_VPP_TIMEOUT_CYC =
        EVCR_VPP_TIMEOUT_MS * EVCR_CLK_HZ / 1000;

    typedef enum logic [1:0] {
        EVCR_PROTO_EXT,
        EVCR_PROTO_DUAL,
        EVCR_PROTO_QUAD
    } evcr_proto_t;

    typedef enum logic {
        EVCR_W_IDLE,
        EVCR_W_VPP
    } evcr_wait_t;

endpackage

// ---- tb/evcr_config_reg_tb.sv ----
// Self-checking bench for the enhanced configuration register block.
// Assumes the host model owns the serial lines; all else is driven here.
`timescale 1ns/1ps
`default_nettype none
module evcr_config_reg_tb
    import evcr_pkg::*;
;
    localparam logic [7:0] opWrite = 8'h61;
    localparam logic [7:0] opRead  = 8'h65;
    logic        clk = 1'b0, srst = 1'b1, vppHigh = 1'b0;
    logic        nvQuadN = 1'b1, nvDualN = 1'b1, nvHoldEn = 1'b0;
    logic [2:0]  nvDrive = 3'h5, driveStrength;
    logic        serialClk, chipSelN, dataIn, dataOut, dataOutEn;
    logic [7:0]  enhancedConfig, cur;
    evcr_proto_t protocol;
    logic        tempExtended, holdResetEnable, accelEnable;
    logic        vppErrorFlag, modifyStart, modifyAccel, lastAccel;
    int          fails = 0, num_checks = 0, starts = 0;

    always #50 clk = ~clk;

    evcr_config_reg #(.VPP_TIMEOUT_CYC(200)) u_evcr_config_reg (
        .clk(clk), .srst(srst), .serialClk(serialClk),
        .chipSelN(chipSelN), .dataIn(dataIn), .vppHigh(vppHigh),
        .nvQuadN(nvQuadN), .nvDualN(nvDualN), .nvHoldEn(nvHoldEn),
        .nvDrive(nvDrive), .dataOut(dataOut), .dataOutEn(dataOutEn),
        .enhancedConfig(enhancedConfig), .protocol(protocol),
        .tempExtended(tempExtended), .holdResetEnable(holdResetEnable),
        .accelEnable(accelEnable), .driveStrength(driveStrength),
        .vppErrorFlag(vppErrorFlag), .modifyStart(modifyStart),
        .modifyAccel(modifyAccel));

    evcr_host_model u_evcr_host_model (
        .serialClk(serialClk), .chipSelN(chipSelN), .dataIn(dataIn),
        .dataOut(dataOut), .dataOutEn(dataOutEn));

    // Start pulses last one cycle, so count them away from the edge
    always @(negedge clk)
        if (modifyStart === 1'b1)
        begin
            starts++;
            lastAccel = modifyAccel;
        end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t %s: %h not %h", $time, what, seen, exp);
        end
    endtask

    function automatic evcr_proto_t proto_of(input logic [7:0] c);
        if (!c[EVCR_QUAD_BIT])
            return EVCR_PROTO_QUAD;
        if (!c[EVCR_DUAL_BIT])
            return EVCR_PROTO_DUAL;
        return EVCR_PROTO_EXT;
    endfunction

    // Register and every field output it feeds
    task automatic check_cfg(input logic [7:0] c);
        check(enhancedConfig, c, "config");
        check({6'h00, protocol}, {6'h00, proto_of(c)}, "proto");
        check({7'h00, holdResetEnable}, {7'h00, c[4]}, "hold");
        check({7'h00, accelEnable}, {7'h00, ~c[3]}, "accel");
        check({5'h00, driveStrength}, {5'h00, c[2:0]}, "drive");
    endtask

    task automatic do_reset(input logic [7:0] c);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        check(enhancedConfig, EVCR_CFG_RESET, "in reset");
        @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(negedge clk);
        cur = c;
        check_cfg(c);
        repeat (5) @(posedge clk);
    endtask

    task automatic read_check();
        logic [7:0] v;
        logic       en;
        u_evcr_host_model.read(opRead, v, en);
        check(v, cur, "readback");
        check({7'h00, en}, 8'h01, "out on");
        check({7'h00, dataOutEn}, 8'h00, "out off");
    endtask

    task automatic write_cfg(input logic [7:0] d);
        logic [7:0] prev;
        prev = cur;
        cur = d & 8'hdf;
        // reserved codes keep the previously written drive
        if (d[2:0] == 3'h0 || d[2:0] == 3'h4)
            cur[2:0] = prev[2:0];
        u_evcr_host_model.send({opWrite, d}, 16);
        @(negedge clk);
        check_cfg(cur);
    endtask

    // Protocol priority, pin functions and every drive code
    task automatic t_fields();
        logic [7:0] tbl [15] = '{8'h7f, 8'hbf, 8'h3f, 8'hbf, 8'hff,
            8'hef, 8'hf7, 8'hf9, 8'hfa, 8'hfb, 8'hfd, 8'hfe, 8'hf8,
            8'hfc, 8'hff};
        foreach (tbl[i])
        begin
            write_cfg(tbl[i]);
            read_check();
        end
    endtask

    // A short write frame must leave the register alone
    task automatic t_refuse();
        u_evcr_host_model.send({opWrite, 8'h00}, 15);
        @(negedge clk);
        check_cfg(cur);
    endtask

    task automatic t_modify(input logic [7:0] c, input logic [7:0] op,
                            input logic raise, input logic expTemp,
                            input logic expAccel, input logic expErr);
        int         s;
        logic [7:0] v;
        logic       en;
        write_cfg(c);
        s = starts;
        u_evcr_host_model.send({op, 8'h00}, 8);
        check({7'h00, tempExtended}, {7'h00, expTemp}, "temp");
        if (expTemp)
        begin
            check({6'h00, protocol}, {6'h00, EVCR_PROTO_EXT}, "fb");
            u_evcr_host_model.read(opRead, v, en);
            check(v, cur, "poll");
        end
        if (raise)
        begin
            check(8'(starts - s), 8'h00, "early");
            @(posedge clk);
            vppHigh <= 1'b1;
        end
        for (int n = 0; n < 400 && starts == s; n++)
            @(negedge clk);
        check(8'(starts - s), 8'h01, "starts");
        check({7'h00, lastAccel}, {7'h00, expAccel}, "speed");
        check({7'h00, vppErrorFlag}, {7'h00, expErr}, "late");
        if (raise)
        begin
            @(posedge clk);
            vppHigh <= 1'b0;
            repeat (10) @(negedge clk);
            check({7'h00, tempExtended}, 8'h00, "temp end");
            check_cfg(cur);
        end
    endtask

    // Error flag survives other frames until the clear instruction
    task automatic t_clear();
        read_check();
        check({7'h00, vppErrorFlag}, 8'h01, "sticky");
        u_evcr_host_model.send({8'h50, 8'h00}, 8);
        check({7'h00, vppErrorFlag}, 8'h00, "cleared");
    endtask

    task automatic give_verdict();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Traffic takes about 1 ms, so 5 ms can only mean a hang
    initial
    begin
        #5_000_000;
        fails++;
        give_verdict();
    end

    // Main sequence: image load, fields, modifies, flag, second power-up
    initial
    begin
        do_reset(8'hcd);
        t_fields();
        t_refuse();
        t_modify(8'h57, 8'h02, 1'b1, 1'b1, 1'b1, 1'b0);
        t_modify(8'hd7, 8'h02, 1'b0, 1'b0, 1'b0, 1'b0);
        t_modify(8'hdf, 8'h32, 1'b0, 1'b0, 1'b0, 1'b0);
        t_modify(8'hd7, 8'h32, 1'b1, 1'b0, 1'b1, 1'b0);
        t_modify(8'hd7, 8'h12, 1'b1, 1'b0, 1'b1, 1'b0);
        t_modify(8'h57, 8'h20, 1'b1, 1'b1, 1'b1, 1'b0);
        t_modify(8'h57, 8'hd8, 1'b0, 1'b1, 1'b0, 1'b1);
        t_clear();
        @(posedge clk);
        nvQuadN  <= 1'b0;
        nvHoldEn <= 1'b1;
        nvDrive  <= 3'h7;
        do_reset(8'h5f);
        give_verdict();
    end
endmodule
`default_nettype wire

// ---- tb/evcr_host_model.sv ----
// Host-side model of the serial controller that issues instructions.
// Assumes the device samples every line with its own system clock.
`timescale 1ns/1ps
`default_nettype none
module evcr_host_model (
    output logic      serialClk,
    output logic      chipSelN,
    output logic      dataIn,
    input  wire logic dataOut,
    input  wire logic dataOutEn
);
    // Link clock stands low between frames; period is 800 ns
    initial
    begin
        serialClk = 1'b0;
        chipSelN  = 1'b1;
        dataIn    = 1'b0;
    end

    // Shift n bits MSB first; data only moves while the clock is low
    task automatic shift(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++)
        begin
            dataIn = v[15-i];
            #400 serialClk = 1'b1;
            #400 serialClk = 1'b0;
        end
    endtask

    // Inverted data after deselect so a stale bit never looks valid
    task automatic finish_frame();
        #400 chipSelN = 1'b1;
        dataIn = ~dataIn;
        #1000;
    endtask

    // Odd start offset keeps the link out of phase with the system clock
    task automatic send(input logic [15:0] v, input int n);
        #37 chipSelN = 1'b0;
        shift(v, n);
        finish_frame();
    endtask

    // Sampled just before the next fall: the answer lags by some clocks
    // An undriven line reads as the inverse so a stale bit never passes
    task automatic read(input logic [7:0] op, output logic [7:0] v,
                        output logic en);
        #37 chipSelN = 1'b0;
        shift({op, 8'h00}, 8);
        for (int i = 0; i < 8; i++)
        begin
            #400 serialClk = 1'b1;
            #390 v[7-i] = dataOutEn ? dataOut : ~dataOut;
            en = dataOutEn;
            #10 serialClk = 1'b0;
        end
        finish_frame();
    endtask
endmodule
`default_nettype wire
